/* File: hdl/imt_pkg.sv */
// Purpose: Shared constants and types for the three-operand integer multiply unit
// Assumes: 32-bit APB data, register offsets are byte addresses
// Notes:   Flag layout mirrors the status word seen by software
package imt_pkg;

	// Instruction word layout
	localparam logic [2:0] PREFIX_CODE  = 3'h1;
	localparam logic [5:0] OPCODE_CODE  = 6'h0A;
	localparam int         PREFIX_MSB   = 31;
	localparam int         PREFIX_LSB   = 29;
	localparam int         OPCODE_MSB   = 28;
	localparam int         OPCODE_LSB   = 23;
	localparam int         MODE_MSB     = 22;
	localparam int         MODE_LSB     = 21;
	localparam int         DST_MSB      = 20;
	localparam int         DST_LSB      = 16;
	localparam int         FIRST_SOURCE_MSB     = 15;
	localparam int         FIRST_SOURCE_LSB     = 8;
	localparam int         SECOND_SOURCE_MSB     = 7;
	localparam int         SECOND_SOURCE_LSB     = 0;

	// Operand, product and result widths; register count and last register numbers
	localparam int         OPND_W       = 24;
	localparam int         PROD_W       = 48;
	localparam int         RES_W        = 32;
	localparam int         NUM_REGS     = 28;
	localparam logic [4:0] LAST_REG     = 5'h1B;
	localparam logic [4:0] LAST_XP_REG  = 5'h07;

	// Indirect displacement selector codes (upper two bits of the modifier)
	localparam logic [1:0] DISP_ONE     = 2'h0;
	localparam logic [1:0] DISP_INDEX0  = 2'h1;
	localparam logic [1:0] DISP_INDEX1  = 2'h2;
	localparam logic [1:0] DISP_ZERO    = 2'h3;

	// Saturation values
	localparam logic [31:0] MOST_POS    = 32'h7FFFFFFF;
	localparam logic [31:0] MOST_NEG    = 32'h80000000;

	// Register offsets
	localparam logic [11:0] OFS_INSTR     = 12'h000;
	localparam logic [11:0] OFS_FLAGS     = 12'h004;
	localparam logic [11:0] OFS_IND_DATA1 = 12'h008;
	localparam logic [11:0] OFS_IND_DATA2 = 12'h00C;
	localparam logic [11:0] OFS_INDEX0    = 12'h010;
	localparam logic [11:0] OFS_INDEX1    = 12'h014;
	localparam logic [11:0] OFS_RF_INDEX  = 12'h018;
	localparam logic [11:0] OFS_RF_DATA   = 12'h01C;
	localparam logic [11:0] OFS_RESULT    = 12'h020;
	localparam logic [11:0] OFS_ENGINE    = 12'h024;
	localparam logic [11:0] OFS_DISP1     = 12'h028;
	localparam logic [11:0] OFS_DISP2     = 12'h02C;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h030;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h034;

	// Flag register bit positions
	localparam int FLG_CARRY     = 0;
	localparam int FLG_OVF       = 1;
	localparam int FLG_ZERO      = 2;
	localparam int FLG_NEG       = 3;
	localparam int FLG_UNF       = 4;
	localparam int FLG_STICKY_OV = 5;
	localparam int FLG_STICKY_UF = 6;
	localparam int FLG_OVM       = 7;

	// Interrupt status bit positions
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_OVF     = 1;
	localparam int IRQ_ILLEGAL = 2;

	// Reset values
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [2:0]  IRQ_RESET   = 3'h0;
	localparam logic [31:0] WORD_RESET  = 32'h00000000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ1,
		ST_READ2,
		ST_EXEC
	} imt_state_type;

endpackage : imt_pkg

/* File: hdl/imt_regfile.sv */
// Purpose: Register file holding the CPU registers seen by the multiply unit
// Assumes: One read port, one write port, single clock
// Notes:   Read data appear one cycle after the read enable
`timescale 1ns/1ps
module imt_regfile #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 28,
	parameter int AW    = 5
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_ff,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Storage array has no reset so it can map onto memory cells
	always_ff @(posedge pclk) begin
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read; out-of-range addresses read as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_ff <= '0;
		end else if (rd_en) begin
			rd_data_ff <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
		end
	end

endmodule : imt_regfile

/* File: hdl/imt_int_multiply_three_op.sv */
// Purpose: Three-operand 24x24 signed integer multiply unit with flags, behind APB
// Assumes: Single clock pclk, asynchronous active-low reset presetn
// Notes:   Indirect operand values are supplied by software in IND_DATA registers
`timescale 1ns/1ps
module imt_int_multiply_three_op #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata_ff,
	output logic                   pready_ff,
	output logic                   pslverr_ff,
	output logic                   irq_ff
);

	imt_pkg::imt_state_type state_ff;

	logic [31:0] instr_ff;
	logic [31:0] ind1_ff;
	logic [31:0] ind2_ff;
	logic [31:0] index0_ff;
	logic [31:0] index1_ff;
	logic [4:0]  rf_index_ff;
	logic [31:0] result_ff;
	logic [31:0] op1_ff;
	logic [7:0]  flags_ff;
	logic [2:0]  irq_stat_ff;
	logic [2:0]  irq_mask_ff;
	logic        rf_wait_ff;
	logic        last_ovf_ff;

	logic [7:0]  nxt_flags;
	logic [2:0]  nxt_irq_stat;
	logic [31:0] nxt_rdata;
	logic [11:0] ofs;
	logic        access;
	logic        xfer_done;
	logic        mapped;
	logic        blocked;
	logic        sw_rf_issue;
	logic        sw_rf_write;
	logic        start_req;
	logic        instr_legal;
	logic        rf_rd_en;
	logic [4:0]  rf_rd_addr;
	logic [31:0] rf_rdata;
	logic        rf_wr_en;
	logic [4:0]  rf_wr_addr;
	logic [31:0] rf_wr_data;
	logic [31:0] op2_word;
	logic signed [23:0] opnd_a;
	logic signed [23:0] opnd_b;
	logic signed [47:0] product;
	logic        ovf;
	logic [31:0] wr_val;
	logic        exec;
	logic        flag_upd;
	logic [2:0]  events;

	// Instruction field views
	logic [1:0]  mode;
	logic [4:0]  dst;
	logic [7:0]  first_source;
	logic [7:0]  second_source;

	// Indirect selection for one source: bit 0 of the mode for the first, bit 1 for the second
	function automatic logic src_indirect(input logic [1:0] m, input logic second);
		src_indirect = second ? m[1] : m[0];
	endfunction : src_indirect

	// Displacement an indirect source field asks for: one, index 0, index 1 or zero
	function automatic logic [31:0] disp_value(input logic [7:0] f, input logic [31:0] ix0,
		input logic [31:0] ix1);
		unique case (f[7:6])
			imt_pkg::DISP_ONE:    disp_value = 32'h00000001;
			imt_pkg::DISP_INDEX0: disp_value = ix0;
			imt_pkg::DISP_INDEX1: disp_value = ix1;
			imt_pkg::DISP_ZERO:   disp_value = 32'h00000000;
		endcase
	endfunction : disp_value

	// A register source must name one of the implemented registers
	function automatic logic reg_ok(input logic [7:0] f);
		reg_ok = (f[7:5] == 3'h0) && (f[4:0] <= imt_pkg::LAST_REG);
	endfunction : reg_ok

	// Field extraction from the latched instruction
	assign mode = instr_ff[imt_pkg::MODE_MSB:imt_pkg::MODE_LSB];
	assign dst  = instr_ff[imt_pkg::DST_MSB:imt_pkg::DST_LSB];
	assign first_source = instr_ff[imt_pkg::FIRST_SOURCE_MSB:imt_pkg::FIRST_SOURCE_LSB];
	assign second_source = instr_ff[imt_pkg::SECOND_SOURCE_MSB:imt_pkg::SECOND_SOURCE_LSB];

	// Bus decode
	assign ofs       = 12'(paddr);
	assign access    = psel && penable;
	assign xfer_done = access && pready_ff;
	assign mapped    = (ofs <= imt_pkg::OFS_IRQ_MASK) && (ofs[1:0] == 2'h0);

	// Instruction writes and register-file accesses stall while the engine runs
	assign blocked = ((ofs == imt_pkg::OFS_INSTR) && pwrite && (state_ff != imt_pkg::ST_IDLE))
		|| ((ofs == imt_pkg::OFS_RF_DATA) && (state_ff != imt_pkg::ST_IDLE));

	assign sw_rf_issue = access && !pready_ff && !pwrite && !rf_wait_ff && !blocked
		&& (ofs == imt_pkg::OFS_RF_DATA);
	assign sw_rf_write = xfer_done && pwrite && (ofs == imt_pkg::OFS_RF_DATA);
	assign start_req   = xfer_done && pwrite && (ofs == imt_pkg::OFS_INSTR);

	// Legality of a freshly written instruction word
	assign instr_legal =
		(pwdata[imt_pkg::PREFIX_MSB:imt_pkg::PREFIX_LSB] == imt_pkg::PREFIX_CODE)
		&& (pwdata[imt_pkg::OPCODE_MSB:imt_pkg::OPCODE_LSB] == imt_pkg::OPCODE_CODE)
		&& (pwdata[imt_pkg::DST_MSB:imt_pkg::DST_LSB] <= imt_pkg::LAST_REG)
		&& (src_indirect(pwdata[imt_pkg::MODE_MSB:imt_pkg::MODE_LSB], 1'b0)
			|| reg_ok(pwdata[imt_pkg::FIRST_SOURCE_MSB:imt_pkg::FIRST_SOURCE_LSB]))
		&& (src_indirect(pwdata[imt_pkg::MODE_MSB:imt_pkg::MODE_LSB], 1'b1)
			|| reg_ok(pwdata[imt_pkg::SECOND_SOURCE_MSB:imt_pkg::SECOND_SOURCE_LSB]));

	// Engine sequence: fetch first source, fetch second, execute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= imt_pkg::ST_IDLE;
		end else begin
			unique case (state_ff)
				imt_pkg::ST_IDLE:  if (start_req && instr_legal) state_ff <= imt_pkg::ST_READ1;
				imt_pkg::ST_READ1: state_ff <= imt_pkg::ST_READ2;
				imt_pkg::ST_READ2: state_ff <= imt_pkg::ST_EXEC;
				imt_pkg::ST_EXEC:  state_ff <= imt_pkg::ST_IDLE;
			endcase
		end
	end

	// Register file port sharing; software only gets it while idle
	assign rf_rd_en   = (state_ff == imt_pkg::ST_READ1) || (state_ff == imt_pkg::ST_READ2)
		|| sw_rf_issue;
	assign rf_rd_addr = (state_ff == imt_pkg::ST_READ1) ? first_source[4:0] :
		(state_ff == imt_pkg::ST_READ2) ? second_source[4:0] : rf_index_ff;
	assign exec       = (state_ff == imt_pkg::ST_EXEC);
	assign rf_wr_en   = exec || sw_rf_write;
	assign rf_wr_addr = exec ? dst : rf_index_ff;
	assign rf_wr_data = exec ? wr_val : pwdata;

	imt_regfile #(
		.WIDTH (32),
		.DEPTH (imt_pkg::NUM_REGS),
		.AW    (5)
	) u_regfile (
		.pclk       (pclk),
		.presetn    (presetn),
		.rd_en      (rf_rd_en),
		.rd_addr    (rf_rd_addr),
		.rd_data_ff (rf_rdata),
		.wr_en      (rf_wr_en),
		.wr_addr    (rf_wr_addr),
		.wr_data    (rf_wr_data)
	);

	// Capture the first operand once its read data are out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op1_ff <= imt_pkg::WORD_RESET;
		end else if (state_ff == imt_pkg::ST_READ2) begin
			op1_ff <= src_indirect(mode, 1'b0) ? ind1_ff : rf_rdata;
		end
	end

	// Datapath; upper source bits are dropped before the signed multiply
	assign op2_word = src_indirect(mode, 1'b1) ? ind2_ff : rf_rdata;
	assign opnd_a   = op1_ff[imt_pkg::OPND_W-1:0];
	assign opnd_b   = op2_word[imt_pkg::OPND_W-1:0];
	assign product  = opnd_a * opnd_b;
	assign ovf      = |(product[imt_pkg::PROD_W-1:imt_pkg::RES_W]
		^ {16{product[imt_pkg::RES_W-1]}});
	// Saturation picks its extreme from the untruncated product sign
	assign wr_val   = (ovf && flags_ff[imt_pkg::FLG_OVM])
		? (product[imt_pkg::PROD_W-1] ? imt_pkg::MOST_NEG : imt_pkg::MOST_POS)
		: product[imt_pkg::RES_W-1:0];
	assign flag_upd = exec && (dst <= imt_pkg::LAST_XP_REG);

	// Flags: software write first, then the engine's update on top
	always_comb begin
		nxt_flags = flags_ff;
		if (xfer_done && pwrite && (ofs == imt_pkg::OFS_FLAGS)) begin
			nxt_flags = pwdata[7:0];
		end
		if (flag_upd) begin
			nxt_flags[imt_pkg::FLG_OVF]       = ovf;
			nxt_flags[imt_pkg::FLG_STICKY_OV] = flags_ff[imt_pkg::FLG_STICKY_OV] | ovf;
			nxt_flags[imt_pkg::FLG_NEG]       = wr_val[imt_pkg::RES_W-1];
			nxt_flags[imt_pkg::FLG_ZERO]      = (wr_val == 32'h00000000);
			nxt_flags[imt_pkg::FLG_UNF]       = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= imt_pkg::FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// Result and last-overflow bookkeeping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff   <= imt_pkg::WORD_RESET;
			last_ovf_ff <= 1'b0;
		end else if (exec) begin
			result_ff   <= wr_val;
			last_ovf_ff <= ovf;
		end
	end

	// Software-owned operand and control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ff    <= imt_pkg::WORD_RESET;
			ind1_ff     <= imt_pkg::WORD_RESET;
			ind2_ff     <= imt_pkg::WORD_RESET;
			index0_ff   <= imt_pkg::WORD_RESET;
			index1_ff   <= imt_pkg::WORD_RESET;
			rf_index_ff <= 5'h00;
			irq_mask_ff <= imt_pkg::IRQ_RESET;
		end else if (xfer_done && pwrite) begin
			unique case (ofs)
				imt_pkg::OFS_INSTR:     instr_ff    <= pwdata;
				imt_pkg::OFS_IND_DATA1: ind1_ff     <= pwdata;
				imt_pkg::OFS_IND_DATA2: ind2_ff     <= pwdata;
				imt_pkg::OFS_INDEX0:    index0_ff   <= pwdata;
				imt_pkg::OFS_INDEX1:    index1_ff   <= pwdata;
				imt_pkg::OFS_RF_INDEX:  rf_index_ff <= pwdata[4:0];
				imt_pkg::OFS_IRQ_MASK:  irq_mask_ff <= pwdata[2:0];
				default:                ;
			endcase
		end
	end

	// Sticky interrupt causes; a new event beats a simultaneous clear
	assign events[imt_pkg::IRQ_DONE]    = exec;
	assign events[imt_pkg::IRQ_OVF]     = exec && ovf;
	assign events[imt_pkg::IRQ_ILLEGAL] = start_req && !instr_legal;

	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (xfer_done && pwrite && (ofs == imt_pkg::OFS_IRQ_STAT)) begin
			nxt_irq_stat = irq_stat_ff & ~pwdata[2:0];
		end
		nxt_irq_stat = nxt_irq_stat | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= imt_pkg::IRQ_RESET;
			irq_ff      <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	// Read data selection
	always_comb begin
		nxt_rdata = 32'h00000000;
		unique case (ofs)
			imt_pkg::OFS_INSTR:     nxt_rdata = instr_ff;
			imt_pkg::OFS_FLAGS:     nxt_rdata = {24'h000000, flags_ff};
			imt_pkg::OFS_IND_DATA1: nxt_rdata = ind1_ff;
			imt_pkg::OFS_IND_DATA2: nxt_rdata = ind2_ff;
			imt_pkg::OFS_INDEX0:    nxt_rdata = index0_ff;
			imt_pkg::OFS_INDEX1:    nxt_rdata = index1_ff;
			imt_pkg::OFS_RF_INDEX:  nxt_rdata = {27'h0000000, rf_index_ff};
			imt_pkg::OFS_RF_DATA:   nxt_rdata = rf_rdata;
			imt_pkg::OFS_RESULT:    nxt_rdata = result_ff;
			imt_pkg::OFS_ENGINE:    nxt_rdata = {30'h00000000, last_ovf_ff,
				(state_ff != imt_pkg::ST_IDLE)};
			imt_pkg::OFS_DISP1:     nxt_rdata = src_indirect(mode, 1'b0)
				? disp_value(first_source, index0_ff, index1_ff) : 32'h00000000;
			imt_pkg::OFS_DISP2:     nxt_rdata = src_indirect(mode, 1'b1)
				? disp_value(second_source, index0_ff, index1_ff) : 32'h00000000;
			imt_pkg::OFS_IRQ_STAT:  nxt_rdata = {29'h00000000, irq_stat_ff};
			imt_pkg::OFS_IRQ_MASK:  nxt_rdata = {29'h00000000, irq_mask_ff};
			default:                nxt_rdata = 32'h00000000;
		endcase
	end

	// Software register-file read waits one cycle for the registered read port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_wait_ff <= 1'b0;
		end else if (xfer_done) begin
			rf_wait_ff <= 1'b0;
		end else if (sw_rf_issue) begin
			rf_wait_ff <= 1'b1;
		end
	end

	// Answer: pready one cycle, with data and error; unmapped answers at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= imt_pkg::WORD_RESET;
		end else if (pready_ff) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= imt_pkg::WORD_RESET;
		end else if (access && !mapped) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= 1'b1;
			prdata_ff  <= imt_pkg::WORD_RESET;
		end else if (access && !blocked && (pwrite || (ofs != imt_pkg::OFS_RF_DATA)
			|| rf_wait_ff)) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= 1'b0;
			prdata_ff  <= pwrite ? imt_pkg::WORD_RESET : nxt_rdata;
		end
	end

endmodule : imt_int_multiply_three_op

/* File: tb/imt_checker_asserts.sv */
// Purpose: Port-level checks of the multiply unit's register bus
// Assumes: Single clock pclk, asynchronous active-low presetn
// Notes:   Sees only the top module's ports, attached by bind
`timescale 1ns/1ps
module imt_checker #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata_ff,
	input wire logic              pready_ff,
	input wire logic              pslverr_ff,
	input wire logic              irq_ff
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Answer is a single pulse tied to a live access
	property p_ready_pulse; pready_ff |=> !pready_ff; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_ready_cause; pready_ff |-> $past(psel && penable) && psel; endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
	property p_err_ready; pslverr_ff |-> pready_ff && prdata_ff == 32'h0; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error outside answer");
	property p_rdata_idle; !pready_ff |-> prdata_ff == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	// Stall on a busy engine is short, so a bound of 16 is generous
	property p_answer; $rose(penable) && psel |-> ##[1:16] pready_ff; endproperty
	a_answer: assert property (p_answer) else $error("access never answered");
	property p_unaligned; pready_ff && paddr[1:0] != 2'h0 |-> pslverr_ff; endproperty
	a_unaligned: assert property (p_unaligned) else $error("misaligned access accepted");
	property p_unmapped; pready_ff && paddr > 'h34 |-> pslverr_ff; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_mapped;
		pready_ff && paddr <= 'h34 && paddr[1:0] == 2'h0 |-> !pslverr_ff;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");

	c_err: cover property (pready_ff && pslverr_ff);
	c_instr: cover property (pready_ff && pwrite && paddr == 'h0);
	c_irq: cover property ($rose(irq_ff));
endmodule : imt_checker

bind imt_int_multiply_three_op imt_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
	.irq_ff(irq_ff));

/* File: tb/imt_apb_master.sv */
// Purpose: Bus master standing in for the CPU side of the multiply unit
// Assumes: Answer comes when pready_ff is seen high at a rising edge
// Notes:   An idle cycle separates transfers, which keeps each signal single-driven
`timescale 1ns/1ps
module imt_apb_master (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata_ff,
	input  wire logic        pready_ff,
	input  wire logic        pslverr_ff
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// One transfer; the request is held until the answering edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_ff !== 1'b1 && n < 64);
		q = prdata_ff;
		e = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) begin
			tb_top.n_mismatch++;
			tb_top.finish_test();
		end
	endtask : xfer
endmodule : imt_apb_master

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the three-operand multiply unit
// Assumes: Flags and results are predicted by the bench's own model
// Notes:   Interrupt mask is left fully open except in the illegal-word test
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, irq_ff, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_ff, q;
	logic [7:0]  fl;
	int          n_mismatch, checked;

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	imt_int_multiply_three_op i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff));
	imt_apb_master i_bfm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
		.pslverr_ff(pslverr_ff));

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_bfm.xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		i_bfm.xfer(1'b0, a, 32'h00000000, q, e);
	endtask : rd

	// Poll status until the given bit shows; a spent bound ends the run
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			rd(imt_pkg::OFS_IRQ_STAT);
			n++;
		end while (q[b] !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			finish_test();
		end
	endtask : poll

	// Reference product; flag bits 1 V, 2 Z, 3 N, 4 UF, 5 LV, 7 OVERFLOW_MODE_BIT
	function automatic logic [31:0] ref_mul(input logic [31:0] a, b, input logic [7:0] f,
		output logic [7:0] nf);
		logic signed [47:0] p;
		logic               ov;
		logic [31:0]        r;
		p = $signed(a[23:0]) * $signed(b[23:0]);
		ov = p[47:32] != {16{p[31]}};
		r = (f[7] && ov) ? (p[47] ? 32'h80000000 : 32'h7FFFFFFF) : p[31:0];
		nf = f;
		nf[1] = ov;
		nf[5] = f[5] | ov;
		nf[4] = 1'b0;
		nf[3] = r[31];
		nf[2] = r == 32'h0;
		return r;
	endfunction : ref_mul

	function automatic logic [31:0] dsp(input logic [7:0] s);
		case (s[7:6])
			2'h0: return 32'h1;
			2'h1: return 32'h5;
			2'h2: return 32'h9;
			default: return 32'h0;
		endcase
	endfunction : dsp

	// Load operands, run one instruction, then check every visible effect
	task automatic run(input logic [1:0] m, input logic [4:0] d, input logic [7:0] s1, s2,
		input logic [31:0] a, b);
		logic [31:0] w;
		logic [7:0]  nf;
		if (m[0]) wr(imt_pkg::OFS_IND_DATA1, a);
		else begin
			wr(imt_pkg::OFS_RF_INDEX, 32'(s1));
			wr(imt_pkg::OFS_RF_DATA, a);
		end
		if (m[1]) wr(imt_pkg::OFS_IND_DATA2, b);
		else begin
			wr(imt_pkg::OFS_RF_INDEX, 32'(s2));
			wr(imt_pkg::OFS_RF_DATA, b);
		end
		w = ref_mul(a, b, fl, nf);
		wr(imt_pkg::OFS_INSTR, {3'h1, 6'h0A, m, d, s1, s2});
		// A register-file read issued at once must stall until the engine is idle
		if (!m[1] && (d == s2[4:0])) begin
			rd(imt_pkg::OFS_RF_DATA);
			chk(q, w);
		end
		poll(0);
		chk(q, {30'h0, nf[1], 1'b1});
		chk(irq_ff, 1'b1);
		rd(imt_pkg::OFS_ENGINE);
		chk(q, {30'h0, nf[1], 1'b0});
		wr(imt_pkg::OFS_IRQ_STAT, 32'h7);
		rd(imt_pkg::OFS_IRQ_STAT);
		chk(q, 32'h0);
		chk(irq_ff, 1'b0);
		if (d <= 5'h07) fl = nf;
		rd(imt_pkg::OFS_RESULT);
		chk(q, w);
		rd(imt_pkg::OFS_FLAGS);
		chk(q, {24'h0, fl});
		rd(imt_pkg::OFS_DISP1);
		chk(q, m[0] ? dsp(s1) : 32'h0);
		rd(imt_pkg::OFS_DISP2);
		chk(q, m[1] ? dsp(s2) : 32'h0);
		wr(imt_pkg::OFS_RF_INDEX, 32'(d));
		rd(imt_pkg::OFS_RF_DATA);
		chk(q, w);
		$display("test done: mode %0d dst %0d", m, d);
	endtask : run

	// Main sequence
	initial begin
		logic [31:0] bad [3];
		presetn = 1'b0;
		fl = 8'h00;
		bad = '{32'h05000102, 32'h22800102, 32'h251C0102};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(imt_pkg::OFS_FLAGS);
		chk(q, 32'h0);
		rd(imt_pkg::OFS_IRQ_STAT);
		chk(q, 32'h0);
		rd(12'h038);
		chk(e, 1'b1);
		chk(q, 32'h0);
		rd(12'h002);
		chk(e, 1'b1);
		wr(imt_pkg::OFS_INDEX0, 32'h5);
		wr(imt_pkg::OFS_INDEX1, 32'h9);
		wr(imt_pkg::OFS_IRQ_MASK, 32'h7);
		$display("test done: reset and map");
		run(2'h0, 5'h05, 8'h01, 8'h05, 32'h0033C251, 32'h0078B600);
		// Known worked case, held against fixed values rather than the model
		rd(imt_pkg::OFS_RESULT);
		chk(q, 32'hE21D9600);
		rd(imt_pkg::OFS_FLAGS);
		chk(q, 32'h0000002A);
		run(2'h3, 5'h02, 8'h40, 8'h80, 32'hAB000004, 32'h12FFFFFE);
		run(2'h1, 5'h00, 8'hC0, 8'h03, 32'h00000000, 32'h00001234);
		run(2'h2, 5'h08, 8'h04, 8'h00, 32'h007FFFFF, 32'h007FFFFF);
		wr(imt_pkg::OFS_FLAGS, 32'hD1);
		fl = 8'hD1;
		run(2'h3, 5'h01, 8'h00, 8'h40, 32'h007FFFFF, 32'h00800000);
		run(2'h0, 5'h07, 8'h0A, 8'h0B, 32'h007FFFFF, 32'h007FFFFF);
		wr(imt_pkg::OFS_RESULT, 32'h55);
		rd(imt_pkg::OFS_RESULT);
		chk(q, 32'h7FFFFFFF);
		// Bad prefix, bad opcode, destination 28: refused with illegal status only
		wr(imt_pkg::OFS_IRQ_MASK, 32'h3);
		foreach (bad[i]) begin
			wr(imt_pkg::OFS_INSTR, bad[i]);
			poll(2);
			chk(q, 32'h4);
			chk(irq_ff, 1'b0);
			wr(imt_pkg::OFS_IRQ_STAT, 32'h4);
			rd(imt_pkg::OFS_FLAGS);
			chk(q, {24'h0, fl});
		end
		$display("test done: illegal words");
		finish_test();
	end
endmodule : tb_top
